/* hdl/tcb_defs.vh */
`ifndef TCB_DEFS_VH
`define TCB_DEFS_VH

// ==========================================================
// Register byte offsets
`define TCB_OFS_DATA        8'h00
`define TCB_OFS_STATUS      8'h04
`define TCB_OFS_CLEAR       8'h08
`define TCB_OFS_ENABLE      8'h0C
`define TCB_OFS_TXSTAT      8'h10
`define TCB_OFS_FIFOINF     8'h14

// ==========================================================
// Command word A fields
`define TCB_A_IOC           31
`define TCB_A_ALIGN_HI      25
`define TCB_A_ALIGN_LO      24
`define TCB_A_OFF_HI        20
`define TCB_A_OFF_LO        16
`define TCB_A_FIRST         13
`define TCB_A_LAST          12
`define TCB_A_SIZE_HI       10
`define TCB_A_SIZE_LO       0

// Command word B fields
`define TCB_B_TAG_HI        31
`define TCB_B_TAG_LO        16
`define TCB_B_LEN_HI        10
`define TCB_B_LEN_LO        0

// End alignment codes
`define TCB_ALIGN_4         2'b00
`define TCB_ALIGN_16        2'b01
`define TCB_ALIGN_32        2'b10
`define TCB_ALIGN_RSVD      2'b11

// ==========================================================
// Status bits, reset values, sizes
`define TCB_ST_LOADED       0
`define TCB_ST_ERROR        1
`define TCB_EVENTS          2
`define TCB_ENABLE_RESET    2'b00
`define TCB_FIFO_WORDS      512
`define TCB_APB_WAIT        1

`endif

/* hdl/tcb_irq.v */
`timescale 1ns/1ps
`include "tcb_defs.vh"

module tcb_irq #(
  parameter N = `TCB_EVENTS
) (
  input  wire         pclk,      // System clock
  input  wire         presetn,   // Async reset, active low
  input  wire         pclken,    // Clock enable
  input  wire [N-1:0] ev_set,    // Event pulses
  input  wire         clr_we,    // Clear register write
  input  wire [N-1:0] clr_data,  // One bits clear status
  input  wire         en_we,     // Enable register write
  input  wire [N-1:0] en_data,   // New enable value
  output reg  [N-1:0] status,    // Sticky status
  output reg  [N-1:0] enable,    // Interrupt enables
  output reg          irq        // Level interrupt
);

  genvar i;

  // ==========================================================
  // Sticky bits, set wins over clear
  generate
    for (i = 0; i < N; i = i + 1)
    begin : g_bit
      always @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
          status[i] <= 1'b0;
        else if (pclken)
        begin
          if (ev_set[i])
            status[i] <= 1'b1;
          else if (clr_we && clr_data[i])
            status[i] <= 1'b0;
        end
      end
    end
  endgenerate

  // ==========================================================
  // Enable and output
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      enable <= `TCB_ENABLE_RESET;
      irq    <= 1'b0;
    end
    else if (pclken)
    begin
      if (en_we)
        enable <= en_data;
      // One cycle behind status, keeps irq a plain flop
      irq <= |(status & enable);
    end
  end

endmodule

/* hdl/tcb_parser.v */
`timescale 1ns/1ps
`include "tcb_defs.vh"

module tcb_parser #(
  parameter DEPTH  = `TCB_FIFO_WORDS,
  parameter FILL_W = 16
) (
  input  wire        pclk,       // System clock, 250 MHz
  input  wire        presetn,    // Async reset, active low
  input  wire        pclken,     // Clock enable, freezes all state
  input  wire        psel,       // APB select
  input  wire        penable,    // APB access phase
  input  wire        pwrite,     // APB direction
  input  wire [7:0]  paddr,      // APB byte address
  input  wire [31:0] pwdata,     // APB write data
  output reg  [31:0] prdata,     // APB read data
  output reg         pready,     // APB ready
  output reg         pslverr,    // APB error, unmapped address
  input  wire        fifo_pop,   // Downstream removed one word
  output reg         out_valid,  // Retained word pulse
  output reg  [31:0] out_data,   // Retained word
  output reg  [3:0]  out_mask,   // Valid bytes of out_data
  output reg         out_last,   // Final word of packet
  output wire        irq         // Interrupt, level, active high
);

  localparam ST_CMDA = 3'b001;
  localparam ST_CMDB = 3'b010;
  localparam ST_DATA = 3'b100;

  reg  [2:0]        state;
  reg               cmd_ioc;
  reg  [1:0]        cmd_align;
  reg  [4:0]        cmd_off;
  reg  [10:0]       cmd_size;
  reg               cmd_first;
  reg               cmd_last;
  reg  [31:0]       pkt_b;
  reg               in_pkt;
  reg               pkt_err;
  reg  [15:0]       pkt_bytes;
  reg  [9:0]        word_idx;
  reg  [FILL_W-1:0] fill;
  reg  [31:0]       tx_status;
  reg               next_done;
  reg               next_err;
  reg               next_fin;

  wire [`TCB_EVENTS-1:0] ev_status;
  wire [`TCB_EVENTS-1:0] ev_enable;

  // ==========================================================
  // APB slave, one wait state
  wire access  = psel && penable;
  wire fire    = access && pready;
  wire wr_fire = fire && pwrite;
  wire rd_fire = fire && !pwrite;
  wire mapped  = (paddr == `TCB_OFS_DATA)   || (paddr == `TCB_OFS_STATUS) ||
                 (paddr == `TCB_OFS_CLEAR)  || (paddr == `TCB_OFS_ENABLE) ||
                 (paddr == `TCB_OFS_TXSTAT) || (paddr == `TCB_OFS_FIFOINF);
  wire data_wr = wr_fire && (paddr == `TCB_OFS_DATA);

  reg [31:0] rd_mux;
  always @*
  begin
    case (paddr)
      `TCB_OFS_STATUS:  rd_mux = {30'h0, ev_status};
      `TCB_OFS_ENABLE:  rd_mux = {30'h0, ev_enable};
      `TCB_OFS_TXSTAT:  rd_mux = tx_status;
      `TCB_OFS_FIFOINF: rd_mux = {{(32-FILL_W){1'b0}}, DEPTH[FILL_W-1:0] - fill};
      default:          rd_mux = 32'h0;
    endcase
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      prdata  <= 32'h0;
      pslverr <= 1'b0;
    end
    else if (pclken)
    begin
      pready  <= access && !pready;
      pslverr <= access && !pready && !mapped;
      prdata  <= (access && !pready && !pwrite) ? rd_mux : 32'h0;
    end
  end

  // ==========================================================
  // Buffer geometry
  // End byte of payload within buffer, offset included
  wire [11:0] buf_end   = {7'h0, cmd_off} + {1'b0, cmd_size};
  wire [11:0] end_rnd   = buf_end + 12'h003;
  wire [9:0]  data_wds  = end_rnd[11:2];
  wire [9:0]  rnd4      = data_wds + 10'h003;
  wire [9:0]  rnd8      = data_wds + 10'h007;
  reg  [9:0]  pad_wds;
  always @*
  begin
    case (cmd_align)
      `TCB_ALIGN_16: pad_wds = {rnd4[9:2], 2'b00};
      `TCB_ALIGN_32: pad_wds = {rnd8[9:3], 3'b000};
      default:       pad_wds = data_wds;
    endcase
  end

  // Byte lanes inside [offset, end) are kept
  wire [11:0] base = {word_idx, 2'b00};
  wire [3:0]  lane_keep;
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1)
    begin : g_lane
      localparam integer LANE = g;
      wire [11:0] pos = {word_idx, LANE[1:0]};
      assign lane_keep[g] = (pos >= {7'h0, cmd_off}) && (pos < buf_end);
    end
  endgenerate

  wire [2:0]  lane_cnt  = {2'b0, lane_keep[0]} + {2'b0, lane_keep[1]} +
                          {2'b0, lane_keep[2]} + {2'b0, lane_keep[3]};
  wire        is_data   = word_idx < data_wds;
  wire        keep      = is_data && (|lane_keep);
  wire        fifo_full = (fill == DEPTH[FILL_W-1:0]) && !fifo_pop;
  wire        push      = data_wr && (state == ST_DATA) && keep && !fifo_full;
  wire        last_wd   = (word_idx + 10'h001) == pad_wds;
  wire [15:0] bytes_now = pkt_bytes + {13'h0, lane_cnt};
  wire        b_zero    = (state == ST_CMDB) && (pad_wds == 10'h000);
  // A buffer closing at its own word B must not see the last packet's leftovers
  wire        b_first   = (state == ST_CMDB) && cmd_first;
  wire [15:0] fin_tag   = b_first ? pwdata[`TCB_B_TAG_HI:`TCB_B_TAG_LO] : pkt_b[`TCB_B_TAG_HI:`TCB_B_TAG_LO];
  wire        fin_err   = b_first ? next_err : (pkt_err | next_err);

  // ==========================================================
  // Event decode
  always @*
  begin
    next_done = 1'b0;
    next_err  = 1'b0;
    next_fin  = 1'b0;
    if (data_wr)
    begin
      case (state)
        ST_CMDB:
        begin
          if (!cmd_first && (!in_pkt || pwdata != pkt_b))
            next_err = 1'b1;
          if (cmd_align == `TCB_ALIGN_RSVD)
            next_err = 1'b1;
          next_fin = b_zero;
        end
        ST_DATA:
        begin
          if (keep && fifo_full)
            next_err = 1'b1;
          next_fin = last_wd;
        end
        default:
        begin
          next_err = 1'b0;
        end
      endcase
      if (next_fin)
      begin
        next_done = cmd_ioc;
        // Length compared once, on the packet's closing buffer
        if (cmd_last && (bytes_now != {5'h0, pkt_b[`TCB_B_LEN_HI:`TCB_B_LEN_LO]}) && (state == ST_DATA))
          next_err = 1'b1;
        if (cmd_last && (state == ST_CMDB) &&
            (pwdata[`TCB_B_LEN_HI:`TCB_B_LEN_LO] != (b_first ? 11'h000 : pkt_bytes[10:0])))
          next_err = 1'b1;
      end
    end
  end

  // ==========================================================
  // Parser state machine
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state     <= ST_CMDA;
      cmd_ioc   <= 1'b0;
      cmd_align <= `TCB_ALIGN_4;
      cmd_off   <= 5'h00;
      cmd_size  <= 11'h000;
      cmd_first <= 1'b0;
      cmd_last  <= 1'b0;
      pkt_b     <= 32'h0;
      in_pkt    <= 1'b0;
      pkt_err   <= 1'b0;
      pkt_bytes <= 16'h0;
      word_idx  <= 10'h000;
    end
    else if (pclken && data_wr)
    begin
      case (state)
        ST_CMDA:
        begin
          // Reserved bits 30:26 are not checked, host keeps them zero
          cmd_ioc   <= pwdata[`TCB_A_IOC];
          cmd_align <= pwdata[`TCB_A_ALIGN_HI:`TCB_A_ALIGN_LO];
          cmd_off   <= pwdata[`TCB_A_OFF_HI:`TCB_A_OFF_LO];
          cmd_size  <= pwdata[`TCB_A_SIZE_HI:`TCB_A_SIZE_LO];
          cmd_first <= pwdata[`TCB_A_FIRST];
          cmd_last  <= pwdata[`TCB_A_LAST];
          state     <= ST_CMDB;
        end
        ST_CMDB:
        begin
          word_idx <= 10'h000;
          if (cmd_first)
          begin
            pkt_b     <= pwdata;
            in_pkt    <= 1'b1;
            pkt_bytes <= 16'h0;
            pkt_err   <= next_err;
          end
          else
            pkt_err <= pkt_err | next_err;
          state <= b_zero ? ST_CMDA : ST_DATA;
          if (b_zero && cmd_last)
            in_pkt <= 1'b0;
        end
        ST_DATA:
        begin
          word_idx  <= word_idx + 10'h001;
          pkt_bytes <= bytes_now;
          pkt_err   <= pkt_err | next_err;
          if (last_wd)
          begin
            state <= ST_CMDA;
            if (cmd_last)
              in_pkt <= 1'b0;
          end
        end
        default:
        begin
          state <= ST_CMDA;
        end
      endcase
    end
  end

  // ==========================================================
  // Retained words, occupancy and completion status
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      out_valid <= 1'b0;
      out_data  <= 32'h0;
      out_mask  <= 4'h0;
      out_last  <= 1'b0;
      fill      <= {FILL_W{1'b0}};
      tx_status <= 32'h0;
    end
    else if (pclken)
    begin
      out_valid <= push;
      if (push)
      begin
        out_data <= pwdata;
        out_mask <= lane_keep;
        out_last <= cmd_last && ((word_idx + 10'h001) == data_wds);
      end
      // Pop without content is ignored to keep fill from wrapping
      if (push && !(fifo_pop && fill != {FILL_W{1'b0}}))
        fill <= fill + 1'b1;
      else if (!push && fifo_pop && fill != {FILL_W{1'b0}})
        fill <= fill - 1'b1;
      if (next_fin && cmd_last)
        tx_status <= {fin_tag, fin_err, 14'h0, 1'b1};
      else if (rd_fire && paddr == `TCB_OFS_TXSTAT)
        tx_status[0] <= 1'b0;
    end
  end

  // ==========================================================
  // Interrupt status
  tcb_irq #(
    .N (`TCB_EVENTS)
  ) u_irq (
    .pclk     (pclk),
    .presetn  (presetn),
    .pclken   (pclken),
    .ev_set   ({next_err, next_done}),
    .clr_we   (wr_fire && paddr == `TCB_OFS_CLEAR),
    .clr_data (pwdata[`TCB_EVENTS-1:0]),
    .en_we    (wr_fire && paddr == `TCB_OFS_ENABLE),
    .en_data  (pwdata[`TCB_EVENTS-1:0]),
    .status   (ev_status),
    .enable   (ev_enable),
    .irq      (irq)
  );

endmodule

/* testbench/tb.sv */
`timescale 1ns/1ps
module tb;
  logic pclk, presetn, pclken, fifo_pop;
  wire psel, penable, pwrite, pready, pslverr, out_valid, out_last, irq, hang;
  wire [7:0] paddr;
  wire [31:0] pwdata, prdata, out_data;
  wire [3:0] out_mask;
  int miscompares, n_compared, sz, off;
  logic [31:0] exp_d[$], a, b, tmp;
  logic [4:0] exp_m[$];
  logic [15:0] tag;
  logic [1:0] al;
  tcb_host u_host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .hang(hang));
  tcb_parser #(.DEPTH(4)) u_dut (.pclk(pclk), .presetn(presetn), .pclken(pclken), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .fifo_pop(fifo_pop), .out_valid(out_valid), .out_data(out_data),
    .out_mask(out_mask), .out_last(out_last), .irq(irq));
  initial
  begin
    pclk = 0;
    forever #2 pclk = ~pclk;
  end
  // ==========================================
  // Checking
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e)
    begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task finish_test;
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge hang)
  begin
    miscompares++;
    finish_test;
  end
  always @(negedge pclk)
    if (out_valid === 1'b1)
    begin
      if (exp_d.size() == 0) chk("extra word", 0, 1);
      else
      begin
        chk("out_data", exp_d.pop_front(), out_data);
        chk("out_mask", exp_m.pop_front(), {out_last, out_mask});
      end
    end
  function automatic int nwords(logic [31:0] c);
    int n, g;
    n = (c[20:16] + c[10:0] + 3) / 4;
    g = (c[25:24] == 2'b01) ? 4 : (c[25:24] == 2'b10) ? 8 : 1;
    return (n + g - 1) / g * g;
  endfunction
  // Builds payload and the words expected out; room caps what is kept
  task automatic send(input logic [31:0] c, d, input int room);
    logic [31:0] q[$], w;
    logic [3:0] m;
    int lo, hi, k;
    lo = c[20:16];
    hi = lo + c[10:0];
    k = 0;
    for (int i = 0; i < nwords(c); i++)
    begin
      w = $urandom;
      q.push_back(w);
      for (int j = 0; j < 4; j++) m[j] = (4 * i + j >= lo) && (4 * i + j < hi);
      if (m != 4'h0 && k < room)
      begin
        exp_d.push_back(w);
        exp_m.push_back({c[12] && 4 * i + 4 >= hi, m});
        k++;
      end
    end
    u_host.put_buf(c, d, q);
  endtask
  task automatic rd_chk(input logic [7:0] ad, input logic [31:0] e, input logic ee);
    logic [31:0] r;
    logic        er;
    u_host.xfer(0, ad, 32'h0, r, er);
    chk("read data", e, r);
    chk("pslverr", ee, er);
  endtask
  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    logic [31:0] r;
    logic        er;
    u_host.xfer(1, ad, d, r, er);
  endtask
  // ==========================================
  // Main sequence
  initial
  begin
    presetn = 0; pclken = 1; fifo_pop = 1;
    tmp = $urandom(32'h43457E96);
    repeat (12) @(posedge pclk);
    presetn <= 1;
    rd_chk(8'h04, 32'h0, 0);
    rd_chk(8'h0C, 32'h0, 0);
    rd_chk(8'h14, 32'h4, 0);
    rd_chk(8'h18, 32'h0, 1);
    wr(8'h0C, 32'h3);
    for (int i = 0; i < 9; i++)
    begin
      tag = $urandom; off = $urandom_range(31); sz = $urandom_range(40, 1); al = i % 3;
      a = {1'b1, 5'h00, al, 3'h0, off[4:0], 4'b0011, 1'b0, sz[10:0]};
      send(a, {tag, 5'h00, sz[10:0]}, 99);
      rd_chk(8'h10, {tag, 16'h0001}, 0);
      rd_chk(8'h04, 32'h1, 0);
      chk("irq", 1, irq);
      wr(8'h08, 32'h1);
      rd_chk(8'h14, 32'h4, 0);
      chk("words left", 0, exp_d.size());
    end
    for (int k = 0; k < 2; k++)
    begin
      tag = $urandom; sz = $urandom_range(20, 1);
      b = {tag, 5'h00, 11'(2 * sz)};
      send({16'h0000, 4'b0010, 1'b0, sz[10:0]}, b, 99);
      send({16'h0000, 4'b0001, 1'b0, sz[10:0]}, b ^ {k[0], 31'h0}, 99);
      rd_chk(8'h04, k ? 32'h2 : 32'h0, 0);
      rd_chk(8'h10, {tag, k ? 16'h8001 : 16'h0001}, 0);
    end
    chk("irq", 1, irq);
    wr(8'h0C, 32'h0);
    rd_chk(8'h0C, 32'h0, 0);
    chk("irq", 0, irq);
    wr(8'h08, 32'h3);
    for (int c = 0; c < 2; c++)
    begin
      tag = $urandom;
      send({6'h00, c ? 2'b11 : 2'b00, 12'h003, 1'b0, 11'd8}, {tag, 5'h00, c ? 11'd8 : 11'd9}, 99);
      rd_chk(8'h04, 32'h2, 0);
      wr(8'h08, 32'h3);
    end
    // Empty buffer closes at word B
    tag = $urandom;
    send({20'h80003, 1'b0, 11'd0}, {tag, 16'h0000}, 99);
    rd_chk(8'h10, {tag, 16'h0001}, 0);
    rd_chk(8'h04, 32'h1, 0);
    wr(8'h08, 32'h3);
    fifo_pop <= 0;
    send({20'h00003, 1'b0, 11'd24}, {tag, 5'h00, 11'd24}, 4);
    rd_chk(8'h14, 32'h0, 0);
    rd_chk(8'h04, 32'h2, 0);
    fifo_pop <= 1;
    repeat (4) @(posedge pclk);
    rd_chk(8'h14, 32'h4, 0);
    chk("words left", 0, exp_d.size());
    finish_test;
  end
endmodule
bind tcb_parser tcb_chk u_chk (.pclk(pclk), .presetn(presetn), .pclken(pclken), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
  .out_valid(out_valid), .out_data(out_data), .out_mask(out_mask), .irq(irq));

/* testbench/tcb_chk.sv */
`timescale 1ns/1ps
module tcb_chk (
  input wire        pclk,      // Clock
  input wire        presetn,   // Reset, active low
  input wire        pclken,    // Clock enable
  input wire        psel,      // APB select
  input wire        penable,   // APB access
  input wire        pwrite,    // APB direction
  input wire [7:0]  paddr,     // APB address
  input wire [31:0] pwdata,    // APB write data
  input wire        pready,    // APB ready
  input wire        pslverr,   // APB error
  input wire        out_valid, // Word pulse
  input wire [31:0] out_data,  // Word
  input wire [3:0]  out_mask,  // Byte lanes
  input wire        irq        // Interrupt
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ==========================================
  // Sequences
  sequence s_done;
    psel && penable && pready && pwrite && pclken;
  endsequence
  sequence s_enoff;
    s_done ##0 (paddr == 8'h0C && pwdata[1:0] == 2'b00);
  endsequence
  // ==========================================
  // Properties
  property p_wait; psel && penable && !pready && pclken |=> pready; endproperty
  property p_one; pready && pclken |=> !pready; endproperty
  property p_err; pslverr |-> pready && (paddr > 8'h14 || paddr[1:0] != 2'b00); endproperty
  property p_src; out_valid |-> $past(psel && penable && pready && pwrite && paddr == 8'h00); endproperty
  property p_data; out_valid |-> out_data == $past(pwdata); endproperty
  property p_lane; out_valid |-> out_mask != 4'h0; endproperty
  property p_cont; out_valid |-> out_mask inside {4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'h6, 4'hC, 4'h7, 4'hE, 4'hF};
  endproperty
  // Irq drops two edges after the enables go off and stays low for three edges
  property p_irq; s_enoff |-> ##2 !irq [*3]; endproperty
  a_wait: assert property (p_wait) else $error("pready late");
  a_one: assert property (p_one) else $error("pready held");
  a_err: assert property (p_err) else $error("pslverr on mapped address");
  a_src: assert property (p_src) else $error("word without data write");
  a_data: assert property (p_data) else $error("word differs from write");
  a_lane: assert property (p_lane) else $error("empty word kept");
  a_cont: assert property (p_cont) else $error("lanes not contiguous");
  a_irq: assert property (p_irq) else $error("irq with enables off");
endmodule

/* testbench/tcb_host.sv */
`timescale 1ns/1ps
module tcb_host (
  input  wire         pclk,    // Clock
  output logic        psel,    // APB select
  output logic        penable, // APB access
  output logic        pwrite,  // APB direction
  output logic [7:0]  paddr,   // APB address
  output logic [31:0] pwdata,  // APB write data
  input  wire  [31:0] prdata,  // APB read data
  input  wire         pready,  // APB ready
  input  wire         pslverr, // APB error
  output logic        hang     // A wait ran out
);
  initial
  begin
    psel = 0; penable = 0; pwrite = 0; paddr = 8'hFF; pwdata = 32'h0; hang = 0;
  end
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
                      output logic e);
    int t;
    @(posedge pclk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    t = 0;
    do begin @(posedge pclk); t++; end while (pready !== 1'b1 && t < 50);
    if (t >= 50) hang <= 1;
    r = prdata; e = pslverr;
    // Released lines other than pwrite show a changed value, never the stale one
    psel <= 0; penable <= 0; paddr <= ~a; pwdata <= ~d;
  endtask
  task automatic put_buf(input logic [31:0] a, b, input logic [31:0] d[$]);
    logic [31:0] r;
    logic        e;
    xfer(1, 8'h00, a, r, e);
    xfer(1, 8'h00, b, r, e);
    foreach (d[i]) xfer(1, 8'h00, d[i], r, e);
  endtask
endmodule
